// ### shared/bmio_pkg.sv
package bmio_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register file offsets, all in the same bank
	localparam logic [7:0] OFS_C_DIR = 8'h10;
	localparam logic [7:0] OFS_C_DAT = 8'h11;
	localparam logic [7:0] OFS_D_DIR = 8'h12;
	localparam logic [7:0] OFS_D_DAT = 8'h13;
	localparam logic [7:0] OFS_E_DIR = 8'h14;
	localparam logic [7:0] OFS_E_DAT = 8'h15;
	localparam logic [3:0] PORT_BANK = 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] DIR_RST   = 8'hFF;
	localparam logic [2:0] E_DIR_RST = 3'h7;
	localparam logic [7:0] LAT_POR   = 8'h00;
	localparam logic [2:0] E_LAT_POR = 3'h0;
	localparam logic [7:0] RD_ZERO   = 8'h00;
	localparam logic [4:0] E_UPPER   = 5'h00;

	////////////////////////////////////////////////////////////////////////
	// Control port bit positions and bus strobe levels
	localparam int         E_ALE_BIT = 0;
	localparam int         E_OE_BIT  = 1;
	localparam int         E_WR_BIT  = 2;
	localparam logic [2:0] E_IDLE    = 3'h6;
	localparam logic [2:0] E_ADDR    = 3'h7;
	localparam logic [2:0] E_RD      = 3'h4;
	localparam logic [2:0] E_WR      = 3'h2;
	localparam logic [2:0] E_ALL_ON  = 3'h7;
	localparam logic [7:0] AD_ALL_ON = 8'hFF;
	localparam logic [7:0] AD_OFF    = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Modes and states
	typedef enum logic [1:0] {
		MODE_MICROPROC = 2'b00,
		MODE_EXT_MCU   = 2'b01,
		MODE_MCU       = 2'b10,
		MODE_PROT_MCU  = 2'b11
	} bmio_mode_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ADDR = 2'b01,
		BUS_STRB = 2'b10,
		BUS_END  = 2'b11
	} bmio_bus_state_type;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [2:0] e;
		logic [7:0] d;
		logic [7:0] c;
	} bmio_pins_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
	} bmio_bus_req_type;

endpackage : bmio_pkg

// ### test/bmio_mem_model.sv
`timescale 1ns/1ps
// External memory on the multiplexed bus; answers in the strobe cycle itself
module bmio_mem_model (
	// Clock
	input  wire logic                    core_clk,
	// Pins as the device drives them
	input  wire bmio_pkg::bmio_pins_type pins_out,
	input  wire bmio_pkg::bmio_pins_type pins_oe,
	// Read data onto the address/data lines
	output      logic [15:0]             rd_data,
	output      logic                    rd_en
);
	logic [15:0] mem [256];
	logic [15:0] addr_r;
	// Address taken while the latch strobe is high; word stored while write is low
	always @(posedge core_clk) begin
		if (pins_oe.e[0] && pins_out.e[0])
			addr_r <= {pins_out.d, pins_out.c};
		if (pins_oe.e[2] && !pins_out.e[2])
			mem[addr_r[7:0] ^ addr_r[15:8]] <= {pins_out.d, pins_out.c};
	end
	// Drives only while output enable is low; the bench shows noise otherwise
	assign rd_en   = pins_oe.e[1] && !pins_out.e[1];
	assign rd_data = mem[addr_r[7:0] ^ addr_r[15:8]];
endmodule : bmio_mem_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	logic                       core_clk = 0, srst = 1, por = 1, m_en;
	logic                       reg_wr_en = 0, reg_rd_en = 0, reg_rvalid;
	logic                       bus_req_valid = 0, bus_req_ready, bus_done;
	logic [3:0]                 bank_select_reg = 4'h1;
	logic [7:0]                 reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
	logic [15:0]                bus_rdata, m_dat, a, d, q;
	logic [7:0]                 lat [3], dir [3];
	bmio_pkg::bmio_mode_type    proc_mode = bmio_pkg::MODE_MCU;
	bmio_pkg::bmio_bus_req_type bus_req = '0;
	bmio_pkg::bmio_pins_type    pins_in, pins_out, pins_oe, ext = '0;
	int                         compares = 0, miscompares = 0;

	always #12.5 core_clk = ~core_clk;

	// Wire level: device drive wins, then the memory, else bench noise
	always_comb begin
		pins_in = (pins_out & pins_oe) | (ext & ~pins_oe);
		// The memory answers only on the bus; in plain I/O modes the pins are the bench's
		if (m_en && (proc_mode == bmio_pkg::MODE_MICROPROC ||
		             proc_mode == bmio_pkg::MODE_EXT_MCU)) begin
			pins_in.c = (pins_out.c & pins_oe.c) | (m_dat[7:0] & ~pins_oe.c);
			pins_in.d = (pins_out.d & pins_oe.d) | (m_dat[15:8] & ~pins_oe.d);
		end
	end

	bmio_ports dut (.core_clk(core_clk), .srst(srst), .por(por), .proc_mode(proc_mode),
		.bank_select_reg(bank_select_reg), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .bus_req_valid(bus_req_valid), .bus_req(bus_req),
		.bus_req_ready(bus_req_ready), .bus_rdata(bus_rdata), .bus_done(bus_done),
		.pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe));
	bmio_mem_model mem (.core_clk(core_clk), .pins_out(pins_out), .pins_oe(pins_oe),
		.rd_data(m_dat), .rd_en(m_en));

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
		@(posedge core_clk);
		#2;
		reg_addr = ad;
		reg_wdata = wd;
		reg_wr_en = 1;
		@(posedge core_clk);
		#2;
		reg_wr_en = 0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [7:0] rv);
		int n;
		@(posedge core_clk);
		#2;
		reg_addr = ad;
		reg_rd_en = 1;
		@(posedge core_clk);
		#2;
		reg_rd_en = 0;
		for (n = 0; reg_rvalid !== 1'b1 && n < 4; n++) begin
			@(posedge core_clk);
			#2;
		end
		if (n == 4) begin
			miscompares++;
			end_of_test();
		end
		rv = reg_rdata;
	endtask : rd

	task automatic bus(input logic [15:0] ba, input logic [15:0] bd, input logic w,
		output logic [15:0] bq);
		int n;
		@(posedge core_clk);
		#2;
		bus_req = '{addr: ba, wdata: bd, wr: w};
		bus_req_valid = 1;
		for (n = 0; bus_req_ready !== 1'b1 && n < 8; n++) begin
			@(posedge core_clk);
			#2;
		end
		if (n == 8) begin
			miscompares++;
			end_of_test();
		end
		@(posedge core_clk);
		#2;
		bus_req_valid = 0;
		for (n = 0; bus_done !== 1'b1 && n < 8; n++) begin
			@(posedge core_clk);
			#2;
		end
		if (n == 8) begin
			miscompares++;
			end_of_test();
		end
		// Done shows after the third edge past the take and is sampled 2 ns after that same edge
		chk(16'(n + 1), 16'h0004);
		bq = bus_rdata;
	endtask : bus

	// One port's bits out of the pin carrier; the control port has three
	function automatic logic [7:0] sl(input bmio_pkg::bmio_pins_type x, input int p);
		return 8'(x >> (8 * p)) & (p == 2 ? 8'h07 : 8'hFF);
	endfunction : sl

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(82));
		repeat (8) @(posedge core_clk);
		#2;
		srst = 0;
		por = 0;
		for (int p = 0; p < 3; p++) begin
			rd(bmio_pkg::OFS_C_DIR + 8'(2 * p), v);
			chk(v, p == 2 ? 8'h07 : 8'hFF);
		end
		// Wrong bank and unmapped place are refused
		bank_select_reg = 4'h2;
		wr(bmio_pkg::OFS_C_DIR, 8'h00);
		rd(bmio_pkg::OFS_C_DIR, v);
		chk(v, 8'h00);
		bank_select_reg = 4'h1;
		rd(bmio_pkg::OFS_C_DIR, v);
		chk(v, 8'hFF);
		rd(8'h16, v);
		chk(v, 8'h00);
		// Plain I/O modes: latches written with random values first, then directions
		for (int m = 2; m < 4; m++) begin
			proc_mode = bmio_pkg::bmio_mode_type'(m);
			for (int i = 0; i < 4; i++) begin
				for (int p = 0; p < 3; p++) begin
					lat[p] = 8'($urandom);
					dir[p] = 8'($urandom);
					wr(bmio_pkg::OFS_C_DAT + 8'(2 * p), lat[p]);
				end
				for (int p = 0; p < 3; p++)
					wr(bmio_pkg::OFS_C_DIR + 8'(2 * p), dir[p]);
				ext = 19'($urandom);
				@(posedge core_clk);
				@(posedge core_clk);
				#2;
				chk(16'(bus_req_ready), 16'h0000);
				for (int p = 0; p < 3; p++) begin
					chk(sl(pins_oe, p), ~dir[p] & sl('1, p));
					chk(sl(pins_out, p), lat[p] & sl('1, p));
					rd(bmio_pkg::OFS_C_DAT + 8'(2 * p), v);
					chk(v, ((lat[p] & ~dir[p]) | sl(ext, p) & dir[p]) & sl('1, p));
				end
			end
		end
		// Pin reset keeps the latch, power-on clears it
		for (int r = 0; r < 2; r++) begin
			srst = (r == 0);
			por = (r == 1);
			repeat (2) @(posedge core_clk);
			#2;
			srst = 0;
			por = 0;
			rd(bmio_pkg::OFS_C_DIR, v);
			chk(v, 8'hFF);
			wr(bmio_pkg::OFS_C_DIR, 8'h00);
			repeat (2) @(posedge core_clk);
			#2;
			chk(pins_out.c, r == 0 ? lat[0] : 8'h00);
		end
		// Bus modes: each word written then read back through the memory
		for (int m = 0; m < 2; m++) begin
			proc_mode = bmio_pkg::bmio_mode_type'(m);
			for (int i = 0; i < 4; i++) begin
				a = 16'($urandom);
				d = 16'($urandom);
				bus(a, d, 1'b1, q);
				bus(a, 16'h0000, 1'b0, q);
				chk(q, d);
				chk({pins_oe.e, pins_out.e}, {3'h7, bmio_pkg::E_IDLE});
			end
		end
		end_of_test();
	end
endmodule : tb

// ### verilog/bmio_ports.sv
`timescale 1ns/1ps
// Operation
// R01: A pin whose direction bit is one is an input with its driver off, on all three ports.
// R02: A pin whose direction bit is zero drives its latch bit.
// R03: Reading a data register returns pin levels; writing updates only the latch.
// R04: In bus modes the low byte port carries address/data bits 7 to 0.
// R05: In bus modes the high byte port carries address/data bits 15 to 8.
// R06: The ports are the system bus only in microprocessor or extended modes, else plain I/O.
// R07: The control port has three pins, each with its own one-means-input direction bit.
// R08: In bus modes the control pins carry address latch, output enable and write strobes.
// R09: Output enable and write strobes are active low, asserted by driving the pin low.
// R10: Upper control data bits read as zero and ignore writes.
// R11: Any reset sets every direction bit to one.
// R12: Latches start undefined at power-on and keep their contents through other resets. The code clears them to zero on power-on.
// R13: Software selects bank one and clears latches before setting directions.
// R14: In bus modes the bus controller overrides direction and latch on the bus pins.
// R15: Data and direction registers are separate eight-bit addressable registers.
module bmio_ports (
	// Clock and resets
	input  wire logic                       core_clk,
	input  wire logic                       srst,
	input  wire logic                       por,
	// Configuration
	input  wire bmio_pkg::bmio_mode_type    proc_mode,
	// Register file port
	input  wire logic [3:0]                 bank_select_reg,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic                       reg_wr_en,
	input  wire logic                       reg_rd_en,
	input  wire logic [7:0]                 reg_wdata,
	output      logic [7:0]                 reg_rdata,
	output      logic                       reg_rvalid,
	// Bus controller request
	input  wire logic                       bus_req_valid,
	input  wire bmio_pkg::bmio_bus_req_type bus_req,
	output      logic                       bus_req_ready,
	output      logic [15:0]                bus_rdata,
	output      logic                       bus_done,
	// Pins
	input  wire bmio_pkg::bmio_pins_type    pins_in,
	output      bmio_pkg::bmio_pins_type    pins_out,
	output      bmio_pkg::bmio_pins_type    pins_oe
);

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0]                   c_dir_r, c_dir_nxt, d_dir_r, d_dir_nxt;
	logic [7:0]                   c_lat_r, c_lat_nxt, d_lat_r, d_lat_nxt;
	logic [2:0]                   e_dir_r, e_dir_nxt, e_lat_r, e_lat_nxt;
	logic [7:0]                   rdata_r, rdata_nxt;
	logic                         rvalid_r, rvalid_nxt;
	logic                         bank_ok;
	logic                         ext_mode;
	// Bus state
	bmio_pkg::bmio_bus_state_type bus_st_r, bus_st_nxt;
	bmio_pkg::bmio_bus_req_type   breq_r, breq_nxt;
	logic [15:0]                  brd_r, brd_nxt;
	logic                         bdone_r, bdone_nxt;
	// Pad state
	bmio_pkg::bmio_pins_type      pout_r, pout_nxt, poe_r, poe_nxt;

	// Bus use depends only on the configured mode
	assign ext_mode = (proc_mode == bmio_pkg::MODE_MICROPROC) ||
	                  (proc_mode == bmio_pkg::MODE_EXT_MCU); // R06
	assign bank_ok  = (bank_select_reg == bmio_pkg::PORT_BANK);

	////////////////////////////////////////////////////////////////////////
	// Register file: six separate 8-bit locations
	always_comb begin
		c_dir_nxt  = c_dir_r;
		d_dir_nxt  = d_dir_r;
		e_dir_nxt  = e_dir_r;
		c_lat_nxt  = c_lat_r;
		d_lat_nxt  = d_lat_r;
		e_lat_nxt  = e_lat_r;
		rdata_nxt  = rdata_r;
		rvalid_nxt = reg_rd_en;
		// Writes are held off under reset so a kept latch cannot be disturbed
		if (reg_wr_en && bank_ok && !srst && !por) begin
			unique case (reg_addr) // R15
				bmio_pkg::OFS_C_DIR: c_dir_nxt = reg_wdata;
				bmio_pkg::OFS_D_DIR: d_dir_nxt = reg_wdata;
				bmio_pkg::OFS_E_DIR: e_dir_nxt = reg_wdata[2:0]; // R07
				bmio_pkg::OFS_C_DAT: c_lat_nxt = reg_wdata; // R03
				bmio_pkg::OFS_D_DAT: d_lat_nxt = reg_wdata; // R03
				bmio_pkg::OFS_E_DAT: e_lat_nxt = reg_wdata[2:0]; // R10
				default: ;
			endcase
		end
		if (reg_rd_en) begin
			rdata_nxt = bmio_pkg::RD_ZERO;
			if (bank_ok) begin
				unique case (reg_addr)
					bmio_pkg::OFS_C_DIR: rdata_nxt = c_dir_r;
					bmio_pkg::OFS_D_DIR: rdata_nxt = d_dir_r;
					bmio_pkg::OFS_E_DIR: rdata_nxt = {bmio_pkg::E_UPPER, e_dir_r};
					bmio_pkg::OFS_C_DAT: rdata_nxt = pins_in.c; // R03
					bmio_pkg::OFS_D_DAT: rdata_nxt = pins_in.d; // R03
					bmio_pkg::OFS_E_DAT: rdata_nxt = {bmio_pkg::E_UPPER, pins_in.e}; // R10
					default: ;
				endcase
			end
		end
		// Latches are only cleared by power-on; other resets leave them alone
		if (por) begin
			c_lat_nxt = bmio_pkg::LAT_POR; // R12
			d_lat_nxt = bmio_pkg::LAT_POR;
			e_lat_nxt = bmio_pkg::E_LAT_POR;
		end
		if (srst || por) begin
			c_dir_nxt  = bmio_pkg::DIR_RST; // R11
			d_dir_nxt  = bmio_pkg::DIR_RST;
			e_dir_nxt  = bmio_pkg::E_DIR_RST;
			rdata_nxt  = bmio_pkg::RD_ZERO;
			rvalid_nxt = 1'b0;
		end
	end

	// Register update
	always_ff @(posedge core_clk) begin
		c_dir_r  <= c_dir_nxt;
		d_dir_r  <= d_dir_nxt;
		e_dir_r  <= e_dir_nxt;
		c_lat_r  <= c_lat_nxt;
		d_lat_r  <= d_lat_nxt;
		e_lat_r  <= e_lat_nxt;
		rdata_r  <= rdata_nxt;
		rvalid_r <= rvalid_nxt;
	end

	assign reg_rdata  = rdata_r;
	assign reg_rvalid = rvalid_r;

	////////////////////////////////////////////////////////////////////////
	// Bus controller: address phase, strobe phase, end phase
	assign bus_req_ready = ext_mode && (bus_st_r == bmio_pkg::BUS_IDLE);

	always_comb begin
		bus_st_nxt = bus_st_r;
		breq_nxt   = breq_r;
		brd_nxt    = brd_r;
		bdone_nxt  = 1'b0;
		unique case (bus_st_r)
			bmio_pkg::BUS_IDLE: begin
				if (bus_req_valid && bus_req_ready) begin
					breq_nxt   = bus_req;
					bus_st_nxt = bmio_pkg::BUS_ADDR;
				end
			end
			bmio_pkg::BUS_ADDR: bus_st_nxt = bmio_pkg::BUS_STRB;
			bmio_pkg::BUS_STRB: bus_st_nxt = bmio_pkg::BUS_END;
			bmio_pkg::BUS_END: begin
				// Strobe is visible on the pins in this cycle, so sample here
				if (!breq_r.wr) begin
					brd_nxt = {pins_in.d, pins_in.c};
				end
				bdone_nxt  = 1'b1;
				bus_st_nxt = bmio_pkg::BUS_IDLE;
			end
		endcase
		// Leaving bus mode abandons a cycle; no done is given for it
		if (srst || !ext_mode) begin
			bus_st_nxt = bmio_pkg::BUS_IDLE; // R06
			bdone_nxt  = 1'b0;
		end
	end

	// Bus state update
	always_ff @(posedge core_clk) begin
		bus_st_r <= bus_st_nxt;
		breq_r   <= breq_nxt;
		brd_r    <= brd_nxt;
		bdone_r  <= bdone_nxt;
	end

	assign bus_rdata = brd_r;
	assign bus_done  = bdone_r;

	////////////////////////////////////////////////////////////////////////
	// Pad drive, registered so the pins never glitch on decode
	always_comb begin
		pout_nxt.c = c_lat_r; // R02
		pout_nxt.d = d_lat_r; // R02
		pout_nxt.e = e_lat_r; // R02
		poe_nxt.c  = ~c_dir_r; // R01
		poe_nxt.d  = ~d_dir_r; // R01
		poe_nxt.e  = ~e_dir_r; // R07
		if (ext_mode) begin
			// Direction and latch are ignored while the bus owns the pins
			poe_nxt.e  = bmio_pkg::E_ALL_ON; // R14
			pout_nxt.e = bmio_pkg::E_IDLE; // R08
			poe_nxt.c  = bmio_pkg::AD_OFF;
			poe_nxt.d  = bmio_pkg::AD_OFF;
			pout_nxt.c = breq_r.addr[7:0];
			pout_nxt.d = breq_r.addr[15:8];
			unique case (bus_st_r)
				bmio_pkg::BUS_ADDR: begin
					pout_nxt.e = bmio_pkg::E_ADDR; // R08
					poe_nxt.c  = bmio_pkg::AD_ALL_ON; // R04
					poe_nxt.d  = bmio_pkg::AD_ALL_ON; // R05
				end
				bmio_pkg::BUS_STRB: begin
					if (breq_r.wr) begin
						pout_nxt.e = bmio_pkg::E_WR; // R09
						pout_nxt.c = breq_r.wdata[7:0]; // R04
						pout_nxt.d = breq_r.wdata[15:8]; // R05
						poe_nxt.c  = bmio_pkg::AD_ALL_ON;
						poe_nxt.d  = bmio_pkg::AD_ALL_ON;
					end else begin
						pout_nxt.e = bmio_pkg::E_RD; // R09
					end
				end
				bmio_pkg::BUS_IDLE, bmio_pkg::BUS_END: ;
			endcase
		end
		// Every driver off while reset is held
		if (srst || por) begin
			poe_nxt  = '0; // R11
			pout_nxt = '0;
		end
	end

	// Pad update
	always_ff @(posedge core_clk) begin
		pout_r <= pout_nxt;
		poe_r  <= poe_nxt;
	end

	assign pins_out = pout_r;
	assign pins_oe  = poe_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst || por);

	a_dir_reset_ones: assert property ( // R11
		@(posedge core_clk) disable iff (1'b0) (srst || por) |=>
		(c_dir_r == bmio_pkg::DIR_RST) && (d_dir_r == bmio_pkg::DIR_RST) &&
		(e_dir_r == bmio_pkg::E_DIR_RST))
		else $error("direction not all inputs after reset");

	a_latch_keep_reset: assert property ( // R12
		@(posedge core_clk) disable iff (1'b0) (srst && !por) |=>
		$stable(c_lat_r) && $stable(d_lat_r) && $stable(e_lat_r))
		else $error("latch changed by non power-up reset");

	a_input_no_drive: assert property ( // R01
		(!ext_mode && $past(!ext_mode) && !$past(srst || por)) |->
		(pins_oe.c == ~$past(c_dir_r)) && (pins_oe.d == ~$past(d_dir_r)))
		else $error("gpio driver enable does not follow direction");

	a_output_latch: assert property ( // R02
		(!ext_mode && $past(!ext_mode) && !$past(srst || por)) |->
		(pins_out.c == $past(c_lat_r)) && (pins_out.d == $past(d_lat_r)) &&
		(pins_out.e == $past(e_lat_r)))
		else $error("gpio pin does not drive latch");

	a_ctrl_dir_bits: assert property ( // R07
		(!ext_mode && $past(!ext_mode) && !$past(srst || por)) |->
		(pins_oe.e == ~$past(e_dir_r)))
		else $error("control pin enable does not follow direction");

	a_read_pin_level: assert property ( // R03
		(reg_rd_en && bank_ok && reg_addr == bmio_pkg::OFS_D_DAT) |=>
		(reg_rvalid && reg_rdata == $past(pins_in.d)))
		else $error("data read did not return pin level");

	a_ctrl_upper_zero: assert property ( // R10
		(reg_rd_en && bank_ok && reg_addr == bmio_pkg::OFS_E_DAT) |=>
		(reg_rdata[7:3] == bmio_pkg::E_UPPER))
		else $error("control upper bits not zero");

	a_bus_addr_low: assert property ( // R04
		(ext_mode && bus_st_r == bmio_pkg::BUS_ADDR) ##1 ext_mode |->
		(pins_out.c == breq_r.addr[7:0]) && (pins_oe.c == bmio_pkg::AD_ALL_ON) && pins_out.e[0])
		else $error("low address byte not on pins with latch strobe");

	a_bus_addr_high: assert property ( // R05
		(ext_mode && bus_st_r == bmio_pkg::BUS_ADDR) ##1 ext_mode |->
		(pins_out.d == breq_r.addr[15:8]) && (pins_oe.d == bmio_pkg::AD_ALL_ON))
		else $error("high address byte not on pins");

	a_strobe_low: assert property ( // R09
		(ext_mode && bus_st_r == bmio_pkg::BUS_STRB) ##1 ext_mode |->
		(pins_out.e[2] == !breq_r.wr) && (pins_out.e[1] == breq_r.wr) && !pins_out.e[0])
		else $error("strobe not driven low");

	a_bus_finishes: assert property ( // R06
		(bus_req_valid && bus_req_ready) ##1 ext_mode [*3] |-> ##1 bus_done)
		else $error("bus cycle did not finish in four cycles");

	a_ctrl_pins_owned: assert property ( // R08
		(ext_mode && $past(ext_mode) && !$past(srst || por)) |->
		(pins_oe.e == bmio_pkg::E_ALL_ON))
		else $error("control pins not driven in bus mode");

	a_gpio_no_bus: assert property ( // R06
		// Ready is judged in the same cycle, as the mode may change at the next edge
		!ext_mode |-> !bus_req_ready ##1 (bus_st_r == bmio_pkg::BUS_IDLE))
		else $error("bus active outside bus mode");

	c_bus_read: cover property (bus_req_valid && bus_req_ready && !bus_req.wr ##4 bus_done);
	c_bus_write: cover property (bus_req_valid && bus_req_ready && bus_req.wr ##4 bus_done);
	c_gpio_drive: cover property (!ext_mode && pins_oe.c == 8'h30);
	c_pin_read: cover property (reg_rd_en && bank_ok && reg_addr == bmio_pkg::OFS_C_DAT);

endmodule : bmio_ports
